// ---- rtl/twt_target.sv ----
// two-wire target end: framing, address match, acknowledge, write busy and standby
// Function
// - data changes only while clock low
// - falling data, clock high starts transfer
// - rising data, clock high stops transfer
// - stop after read returns to standby
// - eight-bit words, acknowledge low on ninth
// - standby at power-up, after stop following a read, and after the write cycle
// - controller recovers with nine clocks, start
// - address prefix, straps, direction; else standby
// - write cycle timed from stop after write
// - busy ignores inputs; acknowledge polling afterwards
`timescale 1ns/1ps
`default_nettype none
module twt_target #(
  parameter int unsigned WRITE_CYCLES = twt_pkg::WRITE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  twt_bus_if.target bus,
  input wire logic [2:0] target_select_straps,
  input wire logic [7:0] rd_data,
  output logic rd_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic standby,
  output logic write_busy
);
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic scl_f_ff, sda_f_ff, nxt_scl_f, nxt_sda_f;
  logic [2:0] scl_cnt_ff, sda_cnt_ff, nxt_scl_cnt, nxt_sda_cnt;
  logic scl_d_ff, sda_d_ff;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  // two flops, then a counter that only accepts a level held past the noise window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      scl_cnt_ff <= 3'h0;
      sda_cnt_ff <= 3'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
      scl_f_ff <= nxt_scl_f;
      sda_f_ff <= nxt_sda_f;
      scl_cnt_ff <= nxt_scl_cnt;
      sda_cnt_ff <= nxt_sda_cnt;
      scl_d_ff <= scl_f_ff;
      sda_d_ff <= sda_f_ff;
    end
  end

  always_comb begin
    nxt_scl_f = scl_f_ff;
    nxt_sda_f = sda_f_ff;
    nxt_scl_cnt = 3'h0;
    nxt_sda_cnt = 3'h0;
    if (scl_sync_ff[1] != scl_f_ff) begin
      nxt_scl_cnt = scl_cnt_ff + 3'h1;
      if (scl_cnt_ff >= 3'(twt_pkg::FILT_CYC)) begin
        nxt_scl_f = scl_sync_ff[1];
        nxt_scl_cnt = 3'h0;
      end
    end
    if (sda_sync_ff[1] != sda_f_ff) begin
      nxt_sda_cnt = sda_cnt_ff + 3'h1;
      if (sda_cnt_ff >= 3'(twt_pkg::FILT_CYC)) begin
        nxt_sda_f = sda_sync_ff[1];
        nxt_sda_cnt = 3'h0;
      end
    end
  end

  assign scl_rise = scl_f_ff & ~scl_d_ff;
  assign scl_fall = ~scl_f_ff & scl_d_ff;
  // a data edge while the clock stays high is framing, never data
  assign start_ev = scl_f_ff & scl_d_ff & sda_d_ff & ~sda_f_ff;
  assign stop_ev = scl_f_ff & scl_d_ff & ~sda_d_ff & sda_f_ff;

  twt_pkg::twt_tgt_e st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] bit_ff, nxt_bit;
  logic rd_ff, nxt_rd;
  logic wrote_ff, nxt_wrote;
  logic oe_ff, nxt_oe;
  logic [22:0] wcnt_ff, nxt_wcnt;
  logic rdr_ff, nxt_rdr;
  logic [7:0] buf_ff [twt_pkg::BUF_DEPTH];
  logic [1:0] cnt_ff;
  logic wr_ptr_ff, rd_ptr_ff;
  logic buf_in_valid, buf_in_ready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= twt_pkg::TWT_IDLE;
      sh_ff <= 8'h00;
      bit_ff <= 4'h0;
      rd_ff <= 1'b0;
      wrote_ff <= 1'b0;
      oe_ff <= 1'b0;
      wcnt_ff <= 23'h0;
      rdr_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      rd_ff <= nxt_rd;
      wrote_ff <= nxt_wrote;
      oe_ff <= nxt_oe;
      wcnt_ff <= nxt_wcnt;
      rdr_ff <= nxt_rdr;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_rd = rd_ff;
    nxt_wrote = wrote_ff;
    nxt_oe = oe_ff;
    nxt_wcnt = wcnt_ff;
    nxt_rdr = 1'b0;
    buf_in_valid = 1'b0;
    if (st_ff == twt_pkg::TWT_BUSY) begin
      // bus is ignored until the write cycle expires, so polls go unanswered
      nxt_oe = 1'b0;
      if (wcnt_ff == 23'h0) begin
        nxt_st = twt_pkg::TWT_IDLE;
      end else begin
        nxt_wcnt = wcnt_ff - 23'h1;
      end
    end else if (stop_ev) begin
      nxt_oe = 1'b0;
      if (wrote_ff) begin
        nxt_st = twt_pkg::TWT_BUSY;
        nxt_wcnt = 23'(WRITE_CYCLES - 1);
      end else begin
        nxt_st = twt_pkg::TWT_IDLE;
      end
      nxt_wrote = 1'b0;
    end else if (start_ev) begin
      nxt_st = twt_pkg::TWT_ADDR;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
    end else begin
      unique case (st_ff)
        twt_pkg::TWT_IDLE: begin
          nxt_oe = 1'b0;
        end
        twt_pkg::TWT_ADDR, twt_pkg::TWT_DATA: begin
          if (st_ff == twt_pkg::TWT_DATA && rd_ff) begin
            // target drives data only after the clock falls
            if (scl_fall) begin
              nxt_oe = ~sh_ff[7];
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_bit = bit_ff + 4'h1;
            end
            if (scl_fall && bit_ff == 4'h8) begin
              nxt_oe = 1'b0;
              nxt_st = twt_pkg::TWT_DACK;
            end
          end else begin
            if (scl_rise) begin
              nxt_sh = {sh_ff[6:0], sda_f_ff};
              nxt_bit = bit_ff + 4'h1;
            end
            if (scl_fall && bit_ff == 4'(twt_pkg::WORD_BITS)) begin
              if (st_ff == twt_pkg::TWT_ADDR) begin
                if (sh_ff[7:4] == twt_pkg::ADDR_PREFIX && sh_ff[3:1] == target_select_straps) begin
                  nxt_oe = 1'b1;
                  nxt_rd = sh_ff[0];
                  nxt_st = twt_pkg::TWT_AACK;
                end else begin
                  nxt_st = twt_pkg::TWT_IDLE;
                end
              end else if (buf_in_ready) begin
                buf_in_valid = 1'b1;
                nxt_wrote = 1'b1;
                nxt_oe = 1'b1;
                nxt_st = twt_pkg::TWT_AACK;
              end else begin
                // a full buffer refuses the word by withholding the acknowledge
                nxt_st = twt_pkg::TWT_DACK;
              end
            end
          end
        end
        twt_pkg::TWT_AACK: begin
          // acknowledge is held across the whole ninth clock
          if (scl_fall) begin
            nxt_oe = 1'b0;
            nxt_bit = 4'h0;
            nxt_st = twt_pkg::TWT_DATA;
            if (rd_ff) begin
              nxt_sh = rd_data;
              nxt_rdr = 1'b1;
              nxt_oe = ~rd_data[7];
              nxt_sh = {rd_data[6:0], 1'b0};
              nxt_bit = 4'h1;
            end
          end
        end
        twt_pkg::TWT_DACK: begin
          // read acknowledge from the controller; a high ends the word stream
          if (scl_rise) begin
            nxt_st = sda_f_ff ? twt_pkg::TWT_IDLE : twt_pkg::TWT_AACK;
          end
          if (!rd_ff && scl_fall) begin
            nxt_st = twt_pkg::TWT_IDLE;
          end
        end
        default: nxt_st = twt_pkg::TWT_IDLE;
      endcase
    end
  end

  // two-entry buffer between the bus and the user side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 2'h0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      buf_ff[0] <= 8'h00;
      buf_ff[1] <= 8'h00;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_ff[wr_ptr_ff] <= sh_ff;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (rx_valid && rx_ready) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      cnt_ff <= cnt_ff + 2'((buf_in_valid && buf_in_ready) ? 1 : 0) - 2'((rx_valid && rx_ready) ? 1 : 0);
    end
  end

  assign buf_in_ready = (cnt_ff != 2'(twt_pkg::BUF_DEPTH));
  assign rx_valid = (cnt_ff != 2'h0);
  assign rx_data = buf_ff[rd_ptr_ff];
  assign rd_ready = rdr_ff;
  assign bus.tgt_sda_oe = oe_ff;
  assign standby = (st_ff == twt_pkg::TWT_IDLE);
  assign write_busy = (st_ff == twt_pkg::TWT_BUSY);
endmodule
`default_nettype wire

// ---- rtl/twt_pkg.sv ----
// shared constants and types for the two-wire target framing link
package twt_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] ADDR_PREFIX = 4'ha;
  localparam logic [2:0] STRAPS_WIDTH_UNUSED = 3'h0;
  // glitch filter: noise suppression time 80 ns, longest time rounds down
  localparam int unsigned NOISE_NS = 80;
  localparam int unsigned FILT_CYC = (NOISE_NS * (CLK_HZ / 1000000)) / 1000;
  // internal write cycle time 5 ms
  localparam int unsigned WRITE_MS = 5;
  localparam int unsigned WRITE_CYC = WRITE_MS * (CLK_HZ / 1000);
  // controller timing step of the serial clock: the high phase lasts one step, the low phase two
  localparam int unsigned HALF_NS = 2500;
  localparam int unsigned HALF_CYC = (HALF_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned RECOVER_CLOCKS = 9;
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    TWT_IDLE = 3'h0,
    TWT_ADDR = 3'h1,
    TWT_AACK = 3'h3,
    TWT_DATA = 3'h2,
    TWT_DACK = 3'h6,
    TWT_BUSY = 3'h7
  } twt_tgt_e;

  typedef enum logic [3:0] {
    TWC_IDLE = 4'h0,
    TWC_RCV = 4'h1,
    TWC_START = 4'h3,
    TWC_BITLO = 4'h2,
    TWC_BITHI = 4'h6,
    TWC_STOPLO = 4'h7,
    TWC_STOPHI = 4'h5,
    TWC_STOPEND = 4'h4
  } twt_ctl_e;
endpackage

// ---- rtl/twt_bus_if.sv ----
// two-wire bus carrier: open-drain lines resolved from the enables
`timescale 1ns/1ps
`default_nettype none
interface twt_bus_if;
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  logic tgt_sda_oe;
  logic scl;
  logic sda;
  // pulled high, pulled low by any enabled driver
  assign scl = ~ctl_scl_oe;
  assign sda = ~(ctl_sda_oe | tgt_sda_oe);
  modport target (input scl, input sda, output tgt_sda_oe);
  modport controller (input scl, input sda, output ctl_scl_oe, output ctl_sda_oe);
endinterface
`default_nettype wire

// ---- rtl/twt_controller.sv ----
// two-wire controller end: start, word, acknowledge, stop and bus recovery
`timescale 1ns/1ps
`default_nettype none
module twt_controller (
  input wire logic clk,
  input wire logic nrst,
  twt_bus_if.controller bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_recover,
  input wire logic [7:0] cmd_data,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_valid
);
  twt_pkg::twt_ctl_e st_ff, nxt_st;
  logic [7:0] half_ff, nxt_half;
  logic [3:0] bit_ff, nxt_bit;
  logic [8:0] sh_ff, nxt_sh;
  logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic stop_ff, nxt_stop, rec_ff, nxt_rec;
  logic [7:0] rsp_ff, nxt_rsp;
  logic ack_ff, nxt_ack, rv_ff, nxt_rv;
  logic [1:0] sda_sync_ff;
  logic tick;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= twt_pkg::TWC_IDLE;
      half_ff <= 8'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      stop_ff <= 1'b0;
      rec_ff <= 1'b0;
      rsp_ff <= 8'h0;
      ack_ff <= 1'b0;
      rv_ff <= 1'b0;
      sda_sync_ff <= 2'h3;
    end else begin
      st_ff <= nxt_st;
      half_ff <= nxt_half;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      stop_ff <= nxt_stop;
      rec_ff <= nxt_rec;
      rsp_ff <= nxt_rsp;
      ack_ff <= nxt_ack;
      rv_ff <= nxt_rv;
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end

  assign tick = (half_ff == 8'h0);
  assign cmd_ready = (st_ff == twt_pkg::TWC_IDLE);

  // the serial clock is a divider of clk; data moves only in its low half
  always_comb begin
    nxt_st = st_ff;
    nxt_half = tick ? 8'(twt_pkg::HALF_CYC - 1) : half_ff - 8'h1;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_stop = stop_ff;
    nxt_rec = rec_ff;
    nxt_rsp = rsp_ff;
    nxt_ack = ack_ff;
    nxt_rv = 1'b0;
    unique case (st_ff)
      twt_pkg::TWC_IDLE: begin
        nxt_half = 8'(twt_pkg::HALF_CYC - 1);
        if (cmd_valid) begin
          nxt_stop = cmd_stop;
          nxt_rec = cmd_recover;
          nxt_sh = {cmd_data, 1'b1};
          nxt_bit = 4'h0;
          if (cmd_recover) begin
            nxt_sda_oe = 1'b0;
            nxt_scl_oe = 1'b1;
            nxt_st = twt_pkg::TWC_BITLO;
          end else if (cmd_start) begin
            nxt_st = twt_pkg::TWC_START;
          end else begin
            nxt_scl_oe = 1'b1;
            nxt_st = twt_pkg::TWC_BITLO;
          end
        end
      end
      twt_pkg::TWC_START: begin
        // release both lines, then pull data low while the clock is high
        if (tick) begin
          if (scl_oe_ff) begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
          end else if (!sda_oe_ff) begin
            nxt_sda_oe = 1'b1;
          end else begin
            // a recovery ends on its start; the next command sends the address without one
            nxt_scl_oe = 1'b1;
            nxt_st = rec_ff ? twt_pkg::TWC_IDLE : twt_pkg::TWC_BITLO;
            nxt_rec = 1'b0;
          end
        end
      end
      twt_pkg::TWC_BITLO: begin
        if (tick) begin
          nxt_sda_oe = rec_ff ? 1'b0 : ~sh_ff[8];
          nxt_st = twt_pkg::TWC_RCV;
        end
      end
      twt_pkg::TWC_RCV: begin
        if (tick) begin
          nxt_scl_oe = 1'b0;
          nxt_st = twt_pkg::TWC_BITHI;
        end
      end
      twt_pkg::TWC_BITHI: begin
        if (tick) begin
          nxt_sh = {sh_ff[7:0], sda_sync_ff[1]};
          nxt_bit = bit_ff + 4'h1;
          nxt_scl_oe = 1'b1;
          nxt_st = twt_pkg::TWC_BITLO;
          if (rec_ff && sda_sync_ff[1]) begin
            // rec_ff stays set so that the start closes the command
            nxt_st = twt_pkg::TWC_START;
            nxt_stop = 1'b0;
          end else if (bit_ff == 4'(twt_pkg::RECOVER_CLOCKS - 1)) begin
            nxt_rsp = sh_ff[7:0];
            nxt_ack = ~sda_sync_ff[1];
            nxt_rv = ~rec_ff;
            nxt_st = (stop_ff || rec_ff) ? twt_pkg::TWC_STOPLO : twt_pkg::TWC_IDLE;
            nxt_rec = 1'b0;
          end
        end
      end
      twt_pkg::TWC_STOPLO: begin
        if (tick) begin
          nxt_sda_oe = 1'b1;
          nxt_st = twt_pkg::TWC_STOPHI;
        end
      end
      twt_pkg::TWC_STOPHI: begin
        if (tick) begin
          nxt_scl_oe = 1'b0;
          nxt_st = twt_pkg::TWC_STOPEND;
        end
      end
      twt_pkg::TWC_STOPEND: begin
        if (tick) begin
          nxt_sda_oe = 1'b0;
          nxt_st = twt_pkg::TWC_IDLE;
        end
      end
      default: nxt_st = twt_pkg::TWC_IDLE;
    endcase
  end

  assign bus.ctl_scl_oe = scl_oe_ff;
  assign bus.ctl_sda_oe = sda_oe_ff;
  assign rsp_data = rsp_ff;
  assign rsp_ack = ack_ff;
  assign rsp_valid = rv_ff;
endmodule
`default_nettype wire

// ---- dv/twt_bus_chk.sv ----
// checker on the two-wire lines between controller and target
`timescale 1ns/1ps
`default_nettype none
module twt_bus_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_ff, sda_ff, addr_ff, rd_ff, act_ff;
  logic [3:0] bit_ff;
  logic [15:0] run_ff;
  logic start_c, stop_c;
  // decoded from raw lines; the ends filter, so they lag by a few cycles
  assign start_c = scl_ff && scl && sda_ff && !sda;
  assign stop_c = scl_ff && scl && !sda_ff && sda;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {scl_ff, sda_ff, addr_ff, rd_ff, act_ff} <= 5'h18;
      bit_ff <= 4'h0;
      run_ff <= 16'h0;
    end else begin
      {scl_ff, sda_ff} <= {scl, sda};
      run_ff <= (scl != scl_ff) ? 16'h0 : run_ff + {15'h0, run_ff != 16'hffff};
      if (start_c) begin
        {addr_ff, rd_ff, act_ff} <= 3'h5;
        bit_ff <= 4'h0;
      end else if (stop_c) begin
        {addr_ff, act_ff} <= 2'h0;
      end else if (scl && !scl_ff) begin
        bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
        rd_ff <= (addr_ff && bit_ff == 4'h7) ? sda : rd_ff;
        addr_ff <= addr_ff && bit_ff != 4'h8;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  tgt_change_low_a: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target data moved with clock high");
  scl_width_a: assert property ($changed(scl) |-> run_ff >= 16'd100)
    else $error("clock phase too short");
  start_hold_a: assert property ($rose(ctl_sda_oe) && scl |-> ctl_sda_oe throughout ##[1:400] $fell(scl))
    else $error("start not held until clock low");
  stop_idle_a: assert property ($fell(ctl_sda_oe) && scl |-> (scl && sda && !tgt_sda_oe) [*8])
    else $error("bus not idle after stop");
  ack_ninth_a: assert property ($rose(scl) && tgt_sda_oe && !rd_ff |-> bit_ff == 4'h8)
    else $error("target drove data outside ninth clock");
  ack_release_a: assert property ($fell(scl) && bit_ff == 4'h0 && !rd_ff && tgt_sda_oe |-> ##[1:20] !tgt_sda_oe)
    else $error("acknowledge not released");
  read_release_a: assert property ($rose(scl) && rd_ff && !addr_ff && bit_ff == 4'h8 |-> !tgt_sda_oe)
    else $error("target drove ninth clock of read word");
  tgt_quiet_a: assert property (tgt_sda_oe |-> act_ff)
    else $error("target drove data outside a transfer");
  cover property (start_c ##[1:400] $fell(scl));
  cover property ($rose(scl) && tgt_sda_oe && bit_ff == 4'h8);
  cover property (stop_c);
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// bench: controller and target joined, plus a lone target driven by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] AW = {twt_pkg::ADDR_PREFIX, STRAP, 1'b0};
  localparam logic [7:0] AR = {twt_pkg::ADDR_PREFIX, STRAP, 1'b1};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic nrst_ctl = 1'b0;
  logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_recover = 1'b0, rx_ready = 1'b0;
  logic [7:0] cmd_data = 8'h0, rd_data = 8'h96;
  logic cmd_ready, rsp_ack, rsp_valid, rd_ready, rx_valid, standby, write_busy, standby2;
  logic [7:0] rsp_data, rx_data;
  int bad_count = 0, checked = 0;
  int rd_cnt = 0, rsp_cnt = 0;
  // both outputs stand for one cycle only, so they are counted as they pass
  always @(posedge clk) begin
    if (rd_ready === 1'b1) rd_cnt++;
    if (rsp_valid === 1'b1) rsp_cnt++;
  end
  always #10 clk = ~clk;
  twt_bus_if twt_bus_if_i ();
  twt_bus_if twt_bus_if_i2 ();
  // long enough that a poll lands inside the write cycle
  twt_target #(.WRITE_CYCLES(8000)) twt_target_i (.clk(clk), .nrst(nrst), .bus(twt_bus_if_i.target),
    .target_select_straps(STRAP), .rd_data(rd_data), .rd_ready(rd_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .standby(standby), .write_busy(write_busy));
  twt_target #(.WRITE_CYCLES(8000)) twt_target_i2 (.clk(clk), .nrst(nrst), .bus(twt_bus_if_i2.target),
    .target_select_straps(3'h2), .rd_data(8'h0), .rd_ready(), .rx_data(), .rx_valid(), .rx_ready(1'b1),
    .standby(standby2), .write_busy());
  twt_controller twt_controller_i (.clk(clk), .nrst(nrst_ctl), .bus(twt_bus_if_i.controller),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_recover(cmd_recover), .cmd_data(cmd_data), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  twt_bus_chk twt_bus_chk_i (.clk(clk), .nrst(nrst && nrst_ctl), .ctl_scl_oe(twt_bus_if_i.ctl_scl_oe),
    .ctl_sda_oe(twt_bus_if_i.ctl_sda_oe), .tgt_sda_oe(twt_bus_if_i.tgt_sda_oe), .scl(twt_bus_if_i.scl),
    .sda(twt_bus_if_i.sda));

  task automatic finish_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    chk_b({7'h0, got}, {7'h0, exp});
  endtask

  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("[ERR] %0t timeout got %h exp %h", $time, sig, lvl);
        finish_test();
      end
    end
  endtask

  // one command: optional start, a byte, optional stop; held until taken
  task automatic xfer(input logic st, input logic sp, input logic rc, input logic [7:0] d);
    @(negedge clk);
    {cmd_valid, cmd_start, cmd_stop, cmd_recover, cmd_data} = {1'b1, st, sp, rc, d};
    wait_lvl(cmd_ready, 1'b1, 100);
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_lvl(cmd_ready, 1'b1, 20000);
    // give the target's input filter time to settle
    repeat (20) @(negedge clk);
  endtask

  task automatic s_noise;
    twt_bus_if_i2.ctl_sda_oe = 1'b1;
    repeat (3) @(negedge clk);
    twt_bus_if_i2.ctl_sda_oe = 1'b0;
    repeat (20) @(negedge clk);
    chk_f(standby2, 1'b1);
    twt_bus_if_i2.ctl_sda_oe = 1'b1;
    repeat (20) @(negedge clk);
    chk_f(standby2, 1'b0);
    twt_bus_if_i2.ctl_sda_oe = 1'b0;
    repeat (20) @(negedge clk);
    chk_f(standby2, 1'b1);
  endtask

  task automatic s_read;
    xfer(1'b1, 1'b0, 1'b0, AR);
    chk_f(rsp_ack, 1'b1);
    chk_f(standby, 1'b0);
    chk_b(8'(rd_cnt), 8'h01);
    xfer(1'b0, 1'b1, 1'b0, 8'hff);
    chk_b(rsp_data, 8'h96);
    chk_f(standby, 1'b1);
    chk_f(write_busy, 1'b0);
  endtask

  task automatic s_mismatch;
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, 1'b1, 1'b0, i ? {4'hb, STRAP, 1'b0} : {twt_pkg::ADDR_PREFIX, 3'h4, 1'b0});
      chk_f(rsp_ack, 1'b0);
      chk_f(standby, 1'b1);
    end
  endtask

  task automatic s_write;
    xfer(1'b1, 1'b0, 1'b0, AW);
    chk_f(rsp_ack, 1'b1);
    xfer(1'b0, 1'b1, 1'b0, 8'h5a);
    chk_f(rsp_ack, 1'b1);
    chk_f(write_busy, 1'b1);
    chk_f(standby, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, AW);
    chk_f(rsp_ack, 1'b0);
    wait_lvl(standby, 1'b1, 10000);
    chk_f(write_busy, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, AW);
    chk_f(rsp_ack, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 8'hc3);
    chk_f(rsp_ack, 1'b1);
    // receiver stalled: third word finds the buffer full
    xfer(1'b0, 1'b1, 1'b0, 8'h0f);
    chk_f(rsp_ack, 1'b0);
    for (int i = 0; i < 2; i++) begin
      chk_f(rx_valid, 1'b1);
      chk_b(rx_data, i ? 8'hc3 : 8'h5a);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
    end
    chk_f(rx_valid, 1'b0);
    wait_lvl(standby, 1'b1, 10000);
  endtask

  task automatic s_recover;
    int n;
    @(negedge clk);
    {cmd_valid, cmd_start, cmd_stop, cmd_recover, cmd_data} = {1'b1, 1'b1, 1'b0, 1'b0, AW};
    wait_lvl(cmd_ready, 1'b1, 100);
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    // controller lost in mid-word while the target still counts bits
    repeat (1000) @(negedge clk);
    nrst_ctl = 1'b0;
    repeat (2) @(negedge clk);
    nrst_ctl = 1'b1;
    // the reset released the clock; let it stand past the checker's 100-cycle minimum phase before recovery
    repeat (120) @(negedge clk);
    n = rsp_cnt;
    xfer(1'b0, 1'b0, 1'b1, 8'hff);
    chk_b(8'(rsp_cnt - n), 8'h00);
    xfer(1'b0, 1'b1, 1'b0, AW);
    chk_f(rsp_ack, 1'b1);
    chk_b(8'(rsp_cnt - n), 8'h01);
    chk_f(standby, 1'b1);
  endtask

  initial begin
    twt_bus_if_i2.ctl_scl_oe = 1'b0;
    twt_bus_if_i2.ctl_sda_oe = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    nrst_ctl = 1'b1;
    repeat (10) @(negedge clk);
    chk_f(standby, 1'b1);
    s_noise();
    s_read();
    s_mismatch();
    s_write();
    s_recover();
    finish_test();
  end
endmodule
`default_nettype wire
